// [include/fsp_cfg.svh]
// Offsets, field positions, opcodes, reset values and timing counts
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

`define FSP_ADDR_W         8
`define FSP_STATUS_OFS     8'h00
`define FSP_CTRL_OFS       8'h04
`define FSP_PROT_OFS       8'h10
`define FSP_PROT_END       8'h1C

`define FSP_ST_READY       0
`define FSP_ST_PROT        1
`define FSP_ST_SWEN        2
`define FSP_ST_GUARD       3
`define FSP_ST_LOCKED      4
`define FSP_ST_DENIED      5
`define FSP_CTRL_CLR_DENY  0

`define FSP_CMD_SP_EN      32'h3D2A_7FA9
`define FSP_CMD_SP_DIS     32'h3D2A_7F9A
`define FSP_CMD_SPR_ERASE  32'h3D2A_7FCF
`define FSP_CMD_BITS       6'h20

`define FSP_BYTE_ERASED    8'hFF
`define FSP_BYTE_CLEAR     8'h00
`define FSP_SPR_RST        128'hFFFF_FFFF_FFFF_FFFF_0000_0000_0000_0000
`define FSP_SUB0A_PAGES    8'h08
`define FSP_SUB_PROT       2'h3

`define FSP_CLK_MHZ        100
`define FSP_GED_NS         1000
`define FSP_GDD_NS         1000
`define FSP_PRE_US         50000
`define FSP_GED_CYC        ((`FSP_GED_NS * `FSP_CLK_MHZ + 999) / 1000)
`define FSP_GDD_CYC        ((`FSP_GDD_NS * `FSP_CLK_MHZ) / 1000)
`define FSP_PRE_CYC        (`FSP_PRE_US * `FSP_CLK_MHZ)

`endif

// [include/fsp_pkg.sv]
// Types shared by the sector protection logic and its bench
package fsp_pkg;

   typedef enum logic {
      FSP_ERS_IDLE,
      FSP_ERS_BUSY
   } fsp_ers_e;

   // Array program or erase request checked against protection
   typedef struct packed {
      logic [3:0] sector;
      logic [7:0] page;
   } fsp_op_s;

   typedef logic [15:0][7:0] fsp_spr_t;

endpackage

// [tb/fsp_host.sv]
// Host serial command sender: MSB first, clock idle low between frames
module fsp_host (
   input  wire logic hclk,
   output logic      spi_cs_n,
   output logic      spi_sck,
   output logic      spi_si
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
      spi_si = 1'b0;
   end
   // Each level held two cycles so the sampler sees every edge
   task automatic frame(input logic [31:0] w);
      spi_cs_n <= 1'b0;
      for (int i = 31; i >= 0; i--) begin
         spi_si <= w[i];
         repeat (2) @(posedge hclk);
         spi_sck <= 1'b1;
         repeat (2) @(posedge hclk);
         spi_sck <= 1'b0;
      end
      repeat (2) @(posedge hclk);
      spi_cs_n <= 1'b1;
      spi_si <= ~w[0];
      repeat (4) @(posedge hclk);
   endtask
endmodule

// [tb/fsp_top_properties.sv]
// Checker of the sector protection top, bound to every instance
module fsp_chk #(
   parameter int GED_CYC = 4,
   parameter int PRE_CYC = 20
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic spi_cs_n,
   input wire logic write_guard_n,
   input wire logic op_req,
   input wire logic op_grant,
   input wire logic op_deny,
   input wire logic ready_busy_flag,
   input wire logic prot_active
);
   timeunit 1ns;
   timeprecision 1ps;
   int low_q;
   int cs_q;
   int busy_q;
   // Raw pin ages, so filter and sync latency need no model
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_q <= 0;
         cs_q <= 0;
         busy_q <= 0;
      end else begin
         low_q <= write_guard_n ? 0 : low_q + 1;
         cs_q <= spi_cs_n ? cs_q + 1 : 0;
         busy_q <= ready_busy_flag ? 0 : busy_q + 1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_cs_new; cs_q inside {[1:6]}; endsequence
   sequence s_guard_long; low_q >= GED_CYC + 6; endsequence
   property p_answer; op_req |=> op_grant ^ op_deny; endproperty
   property p_quiet; !op_req |=> !op_grant && !op_deny; endproperty
   property p_free;
      op_req && !prot_active && ready_busy_flag |=> op_grant;
   endproperty
   property p_busy_deny; op_req && !ready_busy_flag |=> op_deny; endproperty
   property p_guard_wins; s_guard_long |-> prot_active; endproperty
   property p_rise;
      $rose(prot_active) |-> (low_q >= GED_CYC || cs_q inside {[1:6]});
   endproperty
   property p_erase_cs; $fell(ready_busy_flag) |-> s_cs_new; endproperty
   property p_busy_len;
      $rose(ready_busy_flag) |-> busy_q inside {[PRE_CYC-1:PRE_CYC+1]};
   endproperty
   a_answer: assert property (p_answer)
      else $error("op request not answered once");
   a_quiet: assert property (p_quiet)
      else $error("op answer without request");
   a_free: assert property (p_free)
      else $error("op refused with protection off");
   a_busy_deny: assert property (p_busy_deny)
      else $error("op granted during register erase");
   a_guard_wins: assert property (p_guard_wins)
      else $error("guard held but protection off");
   a_rise: assert property (p_rise)
      else $error("protection rose without cause");
   a_erase_cs: assert property (p_erase_cs)
      else $error("erase started away from select release");
   a_busy_len: assert property (p_busy_len)
      else $error("erase busy length wrong");
endmodule

bind fsp_top fsp_chk #(.GED_CYC(GED_CYC), .PRE_CYC(PRE_CYC)) u_chk (
   .hclk(hclk),
   .hresetn(hresetn),
   .spi_cs_n(spi_cs_n),
   .write_guard_n(write_guard_n),
   .op_req(op_req),
   .op_grant(op_grant),
   .op_deny(op_deny),
   .ready_busy_flag(ready_busy_flag),
   .prot_active(prot_active)
);

// [tb/test_flash_sector_protection_logic.sv]
// Self-checking bench of the sector protection top
`include "fsp_cfg.svh"
module test_flash_sector_protection_logic;
   timeunit 1ns;
   timeprecision 1ps;
   import fsp_pkg::*;
   localparam int GED = 4;
   localparam int GDD = 4;
   localparam int PRE = 20;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]  htrans = 0;
   logic        hreadyout, hresp, spi_cs_n, spi_sck, spi_si;
   logic        write_guard_n = 1, op_req = 0, op_grant, op_deny;
   logic        ready_busy_flag, prot_active;
   fsp_op_s     op = '0;
   int          n_errors = 0, samples_checked = 0, cyc = 0;
   always #5 hclk = ~hclk;
   fsp_top #(.GED_CYC(GED), .GDD_CYC(GDD), .PRE_CYC(PRE)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
      .spi_si(spi_si), .write_guard_n(write_guard_n), .op_req(op_req),
      .op(op), .op_grant(op_grant), .op_deny(op_deny),
      .ready_busy_flag(ready_busy_flag), .prot_active(prot_active));
   fsp_host host (.hclk(hclk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
      .spi_si(spi_si));
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0000_0000, {31'h0, hresp});
   endtask
   task automatic opchk(logic [3:0] s, logic [7:0] p, logic g);
      op_req <= 1'b1;
      op <= '{sector: s, page: p};
      @(posedge hclk);
      op_req <= 1'b0;
      @(negedge hclk);
      chk("grant_deny", {30'h0, g, !g}, {30'h0, op_grant, op_deny});
      @(posedge hclk);
   endtask
   task automatic wprot(logic v, int n);
      repeat (n) begin
         @(negedge hclk);
         if (prot_active === v) break;
      end
      chk("prot_active", {31'h0, v}, {31'h0, prot_active});
      @(posedge hclk);
   endtask
   task automatic wrdy(logic v, int n);
      repeat (n) begin
         @(negedge hclk);
         if (ready_busy_flag === v) break;
      end
      chk("ready_busy_flag", {31'h0, v}, {31'h0, ready_busy_flag});
      @(posedge hclk);
   endtask
   task automatic t_reset;
      ahb(0, `FSP_STATUS_OFS, 0);
      chk("status", 32'h0000_0001, rd);
      ahb(0, `FSP_PROT_OFS, 0);
      chk("bytes 0-3", 32'h0000_0000, rd);
      ahb(0, `FSP_PROT_END, 0);
      chk("bytes 12-15", 32'hFFFF_FFFF, rd);
      ahb(0, 8'h80, 0);
      chk("unmapped", 32'h0000_0000, rd);
      opchk(4'hF, 8'h00, 1'b1);
      $display("t_reset done");
   endtask
   task automatic t_erase;
      host.frame(`FSP_CMD_SPR_ERASE);
      wrdy(0, 10);
      opchk(4'h3, 8'h00, 1'b0);
      wrdy(1, PRE + 8);
      ahb(0, `FSP_PROT_OFS, 0);
      chk("erased", 32'hFFFF_FFFF, rd);
      host.frame(`FSP_CMD_SP_EN);
      wprot(1, 8);
      opchk(4'h5, 8'h00, 1'b0);
      ahb(1, `FSP_PROT_OFS, 32'h00FF_00C5);
      ahb(0, `FSP_PROT_OFS, 0);
      chk("programmed", 32'h00FF_00C5, rd);
      opchk(4'h0, 8'h07, 1'b0);
      opchk(4'h0, 8'h08, 1'b1);
      opchk(4'h1, 8'h00, 1'b1);
      opchk(4'h2, 8'h00, 1'b0);
      opchk(4'h3, 8'h00, 1'b1);
      host.frame(`FSP_CMD_SPR_ERASE);
      wrdy(0, 10);
      wrdy(1, PRE + 8);
      opchk(4'h0, 8'h08, 1'b0);
      host.frame(`FSP_CMD_SP_DIS);
      wprot(0, 8);
      opchk(4'h2, 8'h00, 1'b1);
      $display("t_erase done");
   endtask
   task automatic t_guard;
      write_guard_n <= 1'b0;
      repeat (2) @(posedge hclk);
      write_guard_n <= 1'b1;
      repeat (20) @(posedge hclk);
      wprot(0, 1);
      write_guard_n <= 1'b0;
      wprot(1, GED + 12);
      ahb(1, 8'h14, 0);
      ahb(0, 8'h14, 0);
      chk("locked", 32'hFFFF_FFFF, rd);
      host.frame(`FSP_CMD_SPR_ERASE);
      wrdy(1, 1);
      opchk(4'h9, 8'h00, 1'b0);
      host.frame(`FSP_CMD_SP_EN);
      host.frame(`FSP_CMD_SP_DIS);
      write_guard_n <= 1'b1;
      repeat (GDD + 20) @(posedge hclk);
      wprot(1, 1);
      host.frame(`FSP_CMD_SP_DIS);
      wprot(0, 8);
      write_guard_n <= 1'b0;
      wprot(1, GED + 12);
      write_guard_n <= 1'b1;
      wprot(0, GDD + 12);
      ahb(1, 8'h14, 0);
      ahb(0, 8'h14, 0);
      chk("writable", 32'h0000_0000, rd);
      $display("t_guard done");
   endtask
   task automatic t_power;
      // Earlier refusals left the sticky denied bit set
      ahb(0, `FSP_STATUS_OFS, 0);
      chk("status denied", 32'h0000_0021, rd);
      ahb(1, `FSP_CTRL_OFS, 32'h0000_0001);
      ahb(0, `FSP_STATUS_OFS, 0);
      chk("status cleared", 32'h0000_0001, rd);
      host.frame(`FSP_CMD_SP_EN);
      wprot(1, 8);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      wprot(0, 1);
      ahb(0, `FSP_STATUS_OFS, 0);
      chk("status after reset", 32'h0000_0001, rd);
      ahb(0, `FSP_PROT_OFS, 0);
      chk("reloaded", 32'h0000_0000, rd);
      $display("t_power done");
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Ceiling well above the roughly 1400 cycles the run needs
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_erase();
      t_guard();
      t_power();
      print_verdict();
   end
endmodule

// [verilog/fsp_top.sv]
// Sector protection: guard pin filter, SPI commands, register, AHB slave
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`include "fsp_cfg.svh"

module fsp_top
   import fsp_pkg::*;
#(
   parameter int GED_CYC = `FSP_GED_CYC,
   parameter int GDD_CYC = `FSP_GDD_CYC,
   parameter int PRE_CYC = `FSP_PRE_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_sck,
   input  wire logic        spi_si,
   input  wire logic        write_guard_n,
   input  wire logic        op_req,
   input  wire fsp_op_s     op,
   output logic             op_grant,
   output logic             op_deny,
   output logic             ready_busy_flag,
   output logic             prot_active
);

   localparam int CNT_W = $clog2(PRE_CYC + 1);

   // Sub-sector 0a covers the first pages of sector 0
   function automatic logic sec_protected(input fsp_spr_t spr,
                                          input fsp_op_s  o);
      logic [1:0] pat;
      pat = (o.page < `FSP_SUB0A_PAGES) ? spr[0][7:6] : spr[0][5:4];
      if (o.sector == 4'h0) begin
         sec_protected = (pat == `FSP_SUB_PROT);
      end else begin
         // Only the erased pattern protects; other values are undefined
         sec_protected = (spr[o.sector] == `FSP_BYTE_ERASED);
      end
   endfunction

   // ---------------------------------------------------------------
   // Guard pin filter
   // ---------------------------------------------------------------
   logic             guard_q;
   logic [15:0]      gflt_cnt_q;
   logic             guard_raw;

   assign guard_raw = ~write_guard_n;

   // A change must hold for the full delay before it is believed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         guard_q    <= 1'b0;
         gflt_cnt_q <= 16'h0000;
      end else if (guard_raw == guard_q) begin
         gflt_cnt_q <= 16'h0000;
      end else if (guard_q == 1'b0 &&
                   gflt_cnt_q >= 16'(GED_CYC - 1)) begin
         guard_q    <= 1'b1;
         gflt_cnt_q <= 16'h0000;
      end else if (guard_q == 1'b1 &&
                   gflt_cnt_q >= 16'(GDD_CYC - 1)) begin
         guard_q    <= 1'b0;
         gflt_cnt_q <= 16'h0000;
      end else begin
         gflt_cnt_q <= gflt_cnt_q + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // SPI command capture
   // ---------------------------------------------------------------
   logic             sck_q;
   logic             cs_n_q;
   logic [31:0]      shift_q;
   logic [5:0]       nbits_q;
   logic             cs_rise;
   logic             cmd_full;

   assign cs_rise  = spi_cs_n & ~cs_n_q;
   assign cmd_full = (nbits_q == `FSP_CMD_BITS);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sck_q  <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sck_q  <= spi_sck;
         cs_n_q <= spi_cs_n;
      end
   end

   // Longer frames saturate the count and match no opcode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_q <= 32'h0000_0000;
         nbits_q <= 6'h00;
      end else if (spi_cs_n) begin
         nbits_q <= 6'h00;
      end else if (spi_sck && !sck_q) begin
         shift_q <= {shift_q[30:0], spi_si};
         if (nbits_q <= `FSP_CMD_BITS) begin
            nbits_q <= nbits_q + 6'h01;
         end
      end
   end

   logic             cmd_en;
   logic             cmd_dis;
   logic             cmd_ers;

   assign cmd_en  = cs_rise && cmd_full && shift_q == `FSP_CMD_SP_EN;
   assign cmd_dis = cs_rise && cmd_full && shift_q == `FSP_CMD_SP_DIS;
   assign cmd_ers = cs_rise && cmd_full && shift_q == `FSP_CMD_SPR_ERASE;

   // ---------------------------------------------------------------
   // Software protection state
   // ---------------------------------------------------------------
   logic             swen_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         swen_q <= 1'b0;
      end else if (cmd_en) begin
         swen_q <= 1'b1;
      end else if (cmd_dis && !guard_q) begin
         swen_q <= 1'b0;
      end
   end
   // Guard only ORs in, so release leaves swen_q untouched
   logic             prot_now;
   assign prot_now = swen_q | guard_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prot_active <= 1'b0;
      end else begin
         prot_active <= prot_now;
      end
   end

   // ---------------------------------------------------------------
   // Register erase timer
   // ---------------------------------------------------------------
   fsp_ers_e         ers_q;
   logic [CNT_W-1:0] ers_cnt_q;
   logic             ers_start;
   logic             ers_done;
   logic             spr_locked;

   assign spr_locked = guard_q;
   assign ers_start  = cmd_ers && !spr_locked &&
                       ers_q == FSP_ERS_IDLE;
   assign ers_done   = ers_q == FSP_ERS_BUSY &&
                       ers_cnt_q >= CNT_W'(PRE_CYC - 1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ers_q     <= FSP_ERS_IDLE;
         ers_cnt_q <= '0;
      end else begin
         unique case (ers_q)
            FSP_ERS_IDLE: begin
               ers_cnt_q <= '0;
               if (ers_start) begin
                  ers_q <= FSP_ERS_BUSY;
               end
            end
            FSP_ERS_BUSY: begin
               ers_cnt_q <= ers_cnt_q + CNT_W'(1);
               if (ers_done) begin
                  ers_q <= FSP_ERS_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ready_busy_flag <= 1'b1;
      end else begin
         ready_busy_flag <= !(ers_start ||
                              (ers_q == FSP_ERS_BUSY && !ers_done));
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ---------------------------------------------------------------
   logic             ahb_go;
   logic             wr_pend_q;
   logic [7:0]       waddr_q;
   fsp_spr_t         spr_q;
   logic             denied_q;
   logic             prot_hit;
   logic             spr_wr;
   logic [31:0]      rd_mux;

   assign ahb_go   = hsel && hready && htrans[1];
   assign prot_hit = waddr_q >= `FSP_PROT_OFS && waddr_q <= `FSP_PROT_END;
   // Writes act as the program path; erasing before it is up to software
   assign spr_wr   = wr_pend_q && prot_hit && !spr_locked &&
                     ready_busy_flag && !ers_start;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         waddr_q   <= 8'h00;
      end else if (hready) begin
         wr_pend_q <= ahb_go && hwrite;
         waddr_q   <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         spr_q <= `FSP_SPR_RST;
      end else if (ers_done) begin
         spr_q <= {16{`FSP_BYTE_ERASED}};
      end else if (spr_wr) begin
         spr_q[waddr_q[3:2]*4 +: 4] <= hwdata;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (haddr[7:0] == `FSP_STATUS_OFS) begin
         rd_mux[`FSP_ST_READY]  = ready_busy_flag;
         rd_mux[`FSP_ST_PROT]   = prot_active;
         rd_mux[`FSP_ST_SWEN]   = swen_q;
         rd_mux[`FSP_ST_GUARD]  = guard_q;
         rd_mux[`FSP_ST_LOCKED] = spr_locked;
         rd_mux[`FSP_ST_DENIED] = denied_q;
      end else if (haddr[7:0] >= `FSP_PROT_OFS &&
                   haddr[7:0] <= `FSP_PROT_END) begin
         rd_mux = spr_q[haddr[3:2]*4 +: 4];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ahb_go && !hwrite) begin
         hrdata    <= rd_mux;
      end
   end

   // ---------------------------------------------------------------
   // Array operation check
   // ---------------------------------------------------------------
   logic             op_block;
   assign op_block = (prot_now && sec_protected(spr_q, op)) ||
                     !ready_busy_flag || ers_start;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_grant <= 1'b0;
         op_deny  <= 1'b0;
      end else begin
         op_grant <= op_req && !op_block;
         op_deny  <= op_req && op_block;
      end
   end

   // Set wins over a clear in the same cycle
   logic             clr_deny;
   assign clr_deny = wr_pend_q && waddr_q == `FSP_CTRL_OFS &&
                     hwdata[`FSP_CTRL_CLR_DENY];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         denied_q <= 1'b0;
      end else if (op_req && op_block) begin
         denied_q <= 1'b1;
      end else if (clr_deny) begin
         denied_q <= 1'b0;
      end
   end

endmodule
